// ---- inc/sbrg_pkg.sv ----
// Package of register map and field constants for the baud rate generator
package sbrg_pkg;
    // Byte addresses of the APB register words
    localparam logic [7:0] ADDR_LOWER = 8'h00;
    localparam logic [7:0] ADDR_UPPER = 8'h04;
    localparam logic [7:0] ADDR_RATE_CTRL = 8'h08;
    localparam logic [7:0] ADDR_TX_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    // Field positions
    localparam int WIDE_BIT = 3;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int SYNC_BIT = 4;
    localparam int MASTER_BIT = 7;
    // Reset values
    localparam logic [7:0] LOWER_RESET = 8'h00;
    localparam logic [7:0] UPPER_RESET = 8'h00;
    localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
    localparam logic [7:0] TX_CTRL_RESET = 8'h00;
    // Writable masks; other bits read zero
    localparam logic [7:0] RATE_CTRL_MASK = 8'h08;
    localparam logic [7:0] TX_CTRL_MASK = 8'h94;
    // Bit-clock prescale counts (ticks per bit, as count-1)
    localparam logic [5:0] PRESCALE_64 = 6'h3F;
    localparam logic [5:0] PRESCALE_16 = 6'h0F;
    localparam logic [5:0] PRESCALE_4 = 6'h03;
endpackage : sbrg_pkg

// ---- rtl/sbrg_timer.sv ----
// Free-running reloadable down-counter of the baud rate generator
`timescale 1ns/1ps
module sbrg_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control
    input wire logic restart,
    input wire logic [15:0] reload,
    // Result
    output logic tick
);
    logic [15:0] count_q;

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            count_q <= reload;
        end else if (count_q == 16'h0000) begin
            count_q <= reload;
        end else begin
            count_q <= count_q - 16'h0001;
        end
    end

    assign tick = (count_q == 16'h0000) && !restart && !srst;

    a_tick_period: assert property (@(posedge clk) disable iff (srst)
        (tick && !restart && reload == 16'h0001) ##1 !restart
        |-> !tick ##1 (tick || restart))
        else $error("timer period wrong for divisor one");

    a_reload_value: assert property (@(posedge clk) disable iff (srst)
        (tick || restart) |=> count_q == $past(reload))
        else $error("timer not reloaded with divisor");
endmodule : sbrg_timer

// ---- rtl/sbrg_core.sv ----
// APB-programmed baud rate generator producing bit-rate ticks
//
// Summary of operation
// - Generator supports 8 and 16-bit divisors
// - Reset selects 8-bit; wide bit selects 16
// - Divisor sets free-running timer period
// - Async rate uses high-speed and wide bits
// - Sync mode ignores high-speed bit
// - Rates apply only to internal master clock
// - Divisor write restarts timer immediately
// - Rate derives from system clock
// - Divisor is upper byte over lower
// - Async slow mode: clock over 64(n+1)
`timescale 1ns/1ps
module sbrg_core (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Rate outputs to transmitter and receiver
    output logic timer_tick,
    output logic bit_tick,
    output logic rate_enable
);
    logic [7:0] lower_q;
    logic [7:0] upper_q;
    logic [7:0] rate_ctrl_q;
    logic [7:0] tx_ctrl_q;
    logic [7:0] lower_d;
    logic [7:0] upper_d;
    logic [5:0] pre_q;
    logic [5:0] pre_max;
    logic [15:0] divisor;
    logic tick;
    logic restart;
    logic wr_en;
    logic wide;
    logic fast;
    logic sync_mode;
    logic master;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    assign wr_en = psel && penable && pwrite && pready;
    assign wide = rate_ctrl_q[sbrg_pkg::WIDE_BIT];
    assign fast = tx_ctrl_q[sbrg_pkg::HIGH_SPEED_BIT];
    assign sync_mode = tx_ctrl_q[sbrg_pkg::SYNC_BIT];
    assign master = tx_ctrl_q[sbrg_pkg::MASTER_BIT];

    // New byte reaches the timer at the write edge, not a period late
    assign lower_d = (wr_en && hit(paddr, sbrg_pkg::ADDR_LOWER)) ?
        pwdata[7:0] : lower_q;
    assign upper_d = (wr_en && hit(paddr, sbrg_pkg::ADDR_UPPER)) ?
        pwdata[7:0] : upper_q;

    // Upper over lower; 8-bit drops upper
    assign divisor = wide ? {upper_d, lower_d} : {8'h00, lower_d};

    assign restart = wr_en && (hit(paddr, sbrg_pkg::ADDR_LOWER)
        || hit(paddr, sbrg_pkg::ADDR_UPPER));

    // Register writes
    always_ff @(posedge clk) begin
        if (srst) begin
            lower_q <= sbrg_pkg::LOWER_RESET;
            upper_q <= sbrg_pkg::UPPER_RESET;
            rate_ctrl_q <= sbrg_pkg::RATE_CTRL_RESET;
            tx_ctrl_q <= sbrg_pkg::TX_CTRL_RESET;
        end else if (wr_en) begin
            if (hit(paddr, sbrg_pkg::ADDR_LOWER)) begin
                lower_q <= pwdata[7:0];
            end
            if (hit(paddr, sbrg_pkg::ADDR_UPPER)) begin
                upper_q <= pwdata[7:0];
            end
            if (hit(paddr, sbrg_pkg::ADDR_RATE_CTRL)) begin
                rate_ctrl_q <= pwdata[7:0] & sbrg_pkg::RATE_CTRL_MASK;
            end
            if (hit(paddr, sbrg_pkg::ADDR_TX_CTRL)) begin
                tx_ctrl_q <= pwdata[7:0] & sbrg_pkg::TX_CTRL_MASK;
            end
        end
    end

    // Single wait state keeps read data registered
    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (hit(paddr, sbrg_pkg::ADDR_LOWER)) begin
                prdata <= {24'h000000, lower_q};
            end else if (hit(paddr, sbrg_pkg::ADDR_UPPER)) begin
                prdata <= {24'h000000, upper_q};
            end else if (hit(paddr, sbrg_pkg::ADDR_RATE_CTRL)) begin
                prdata <= {24'h000000, rate_ctrl_q};
            end else if (hit(paddr, sbrg_pkg::ADDR_TX_CTRL)) begin
                prdata <= {24'h000000, tx_ctrl_q};
            end else if (hit(paddr, sbrg_pkg::ADDR_STATUS)) begin
                prdata <= {26'h0, pre_q};
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    sbrg_timer u_timer (
        .clk(clk),
        .srst(srst),
        .restart(restart),
        .reload(divisor),
        .tick(tick)
    );

    always_comb begin
        pre_max = sbrg_pkg::PRESCALE_4;
        if (sync_mode) begin
            pre_max = sbrg_pkg::PRESCALE_4;
        end else if (!wide && !fast) begin
            pre_max = sbrg_pkg::PRESCALE_64;
        end else if (wide ^ fast) begin
            pre_max = sbrg_pkg::PRESCALE_16;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            pre_q <= 6'h00;
        end else if (tick) begin
            pre_q <= (pre_q >= pre_max) ? 6'h00 : pre_q + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            timer_tick <= 1'b0;
            bit_tick <= 1'b0;
            rate_enable <= 1'b0;
        end else begin
            timer_tick <= tick;
            bit_tick <= tick && (pre_q >= pre_max);
            rate_enable <= master || !sync_mode;
        end
    end

    a_restart_quiet: assert property (@(posedge clk) disable iff (srst)
        (restart && divisor != 16'h0000)
        |=> !timer_tick ##1 !timer_tick)
        else $error("tick right after divisor write");

    a_slow_prescale: assert property (@(posedge clk) disable iff (srst)
        (!sync_mode && !wide && !fast) |-> pre_max == 6'h3F)
        else $error("slow mode prescale not 64");

    a_sync_ignores: assert property (@(posedge clk) disable iff (srst)
        sync_mode |-> pre_max == 6'h03)
        else $error("sync prescale not 4");

    a_mid_prescale: assert property (@(posedge clk) disable iff (srst)
        (!sync_mode && (wide ^ fast)) |-> pre_max == 6'h0F)
        else $error("mid prescale not 16");

    a_narrow_div: assert property (@(posedge clk) disable iff (srst)
        !wide |-> divisor[15:8] == 8'h00)
        else $error("upper byte used in 8-bit mode");

    a_bit_on_timer: assert property (@(posedge clk) disable iff (srst)
        bit_tick |-> timer_tick)
        else $error("bit tick without timer tick");

    a_slave_off: assert property (@(posedge clk) disable iff (srst)
        (sync_mode && !master) |=> !rate_enable)
        else $error("rate enabled in sync slave");

    a_apb_ready: assert property (@(posedge clk) disable iff (srst)
        (psel && penable && !pready) |=> pready)
        else $error("apb ready late");
endmodule : sbrg_core

// ---- testbench/sbrg_link_model.sv ----
// Serial engine model measuring the rate tick spacing
`timescale 1ns/1ps
module sbrg_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Ticks from the generator
    input wire logic timer_tick,
    input wire logic bit_tick,
    input wire logic rate_enable,
    // Measured gaps
    output logic [31:0] bit_gap,
    output logic [31:0] timer_gap,
    output logic [31:0] bit_count
);
    logic [31:0] bit_run;
    logic [31:0] timer_run;
    // Bits paced only by internal clock
    always_ff @(posedge clk) begin
        if (srst || !rate_enable) begin
            bit_run <= 32'h1;
            if (srst) begin
                bit_count <= 32'h0;
            end
        end else if (bit_tick) begin
            bit_gap <= bit_run;
            bit_count <= bit_count + 32'h1;
            bit_run <= 32'h1;
        end else begin
            bit_run <= bit_run + 32'h1;
        end
    end
    // Timer expiries seen as a free run
    always_ff @(posedge clk) begin
        timer_run <= (srst || timer_tick) ? 32'h1 : timer_run + 32'h1;
        if (timer_tick) begin
            timer_gap <= timer_run;
        end
    end
endmodule : sbrg_link_model

// ---- testbench/serial_baud_rate_generator_tb.sv ----
// Self-checking bench of the baud rate generator
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
    logic clk, srst, psel, penable, pwrite, pready, pslverr;
    logic timer_tick, bit_tick, rate_enable;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, bit_gap, timer_gap, bit_count, rnd, c0;
    logic [32:0] exp_q[$];
    int num_errors = 0, n_compared = 0, cnt, nn, pre;
    logic [2:0] modes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    sbrg_core u_dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_tick(timer_tick), .bit_tick(bit_tick),
        .rate_enable(rate_enable));
    sbrg_link_model u_model (.clk(clk), .srst(srst),
        .timer_tick(timer_tick), .bit_tick(bit_tick),
        .rate_enable(rate_enable), .bit_gap(bit_gap),
        .timer_gap(timer_gap), .bit_count(bit_count));
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task test_done();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    // Request held until pready seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check(prdata, exp_q[0][31:0]);
            check({31'h0, pslverr}, {31'h0, exp_q[0][32]});
            void'(exp_q.pop_front());
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        rnd = 32'h2D8B43A1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        // Reset values, masks, unmapped place
        for (int a = 0; a < 16; a += 4) apb(0, 8'(a), 0, 33'h0);
        apb(1, sbrg_pkg::ADDR_RATE_CTRL, 32'hFF, 0);
        apb(1, sbrg_pkg::ADDR_TX_CTRL, 32'hFF, 0);
        apb(0, sbrg_pkg::ADDR_RATE_CTRL, 0, 33'h08);
        apb(0, sbrg_pkg::ADDR_TX_CTRL, 0, 33'h94);
        apb(1, 8'h14, 32'h5A, 0);
        apb(0, 8'h14, 0, 33'h1_0000_0000);
        $display("Test registers done");
        foreach (modes[i]) begin
            rnd = lfsr(rnd);
            nn = modes[i][1] ? {rnd[8], 4'h0, rnd[3:0]} : rnd[3:0];
            pre = (modes[i][2] || modes[i][1:0] == 2'h3) ? 4 :
                  (modes[i][1] || modes[i][0]) ? 16 : 64;
            apb(1, sbrg_pkg::ADDR_TX_CTRL, {modes[i][2], 2'h0,
                modes[i][2], 1'b0, modes[i][0], 2'h0}, 0);
            apb(1, sbrg_pkg::ADDR_RATE_CTRL, {modes[i][1], 3'h0}, 0);
            apb(1, sbrg_pkg::ADDR_UPPER,
                modes[i][1] ? {7'h0, rnd[8]} : rnd[15:8], 0);
            apb(1, sbrg_pkg::ADDR_LOWER, rnd[3:0], 0);
            cnt = 0;
            do begin
                @(negedge clk);
                cnt++;
            end while (timer_tick !== 1'b1 && cnt < 9000);
            check(cnt, nn + 2);
            c0 = bit_count;
            while (bit_count < c0 + 2) @(negedge clk);
            check(rate_enable, 32'h1);
            check(timer_gap, nn + 1);
            check(bit_gap, pre * (nn + 1));
            $display("Test mode %0d done", i);
        end
        // Sync slave: clock from outside
        apb(1, sbrg_pkg::ADDR_TX_CTRL, 32'h10, 0);
        repeat (3) @(negedge clk);
        check(rate_enable, 32'h0);
        $display("Test slave done");
        test_done();
    end
endmodule : serial_baud_rate_generator_tb
